// *** bench/csl_flash_model.sv ***
// behavioural program flash answering the loader's word reads
`timescale 1ns/1ps
`include "csl_regs.svh"
module csl_flash_model
  import csl_pkg::*;
(
  input wire logic clk,
  input wire csl_addr_t flash_addr,
  input wire logic flash_rd,
  input wire csl_word_t w_one,
  input wire csl_word_t w_two,
  output csl_word_t flash_data
);
  initial flash_data = 24'h5A5A5A;
  // word good for one cycle only; inverted after so a late capture shows
  always @(posedge clk)
  begin
    if (flash_rd)
      flash_data <= (flash_addr == `CSL_WORD_ONE_ADDR) ? w_one : w_two;
    else
      flash_data <= ~flash_data;
  end
endmodule // csl_flash_model

// *** bench/csl_loader_monitor.sv ***
// port checker for the config shadow loader
`timescale 1ns/1ps
module csl_loader_monitor
  import csl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire csl_addr_t flash_addr,
  input wire logic flash_rd,
  input wire csl_addr_t tbl_addr,
  input wire logic tbl_rd,
  input wire csl_byte_t tbl_data,
  input wire logic tbl_valid,
  input wire logic load_done,
  input wire logic dep_rst,
  input wire logic code_protect,
  input wire logic write_protect
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_dep_inverse: assert property (dep_rst == !load_done)
    else $error("dep_rst wrong");
  chk_first_fetch: assert property ($fell(rst) |=> flash_rd && flash_addr == 24'h002BFC)
    else $error("first fetch wrong");
  chk_fetch_order: assert property (flash_rd && flash_addr == 24'h002BFC |-> ##3
    flash_rd && flash_addr == 24'h002BFE) else $error("fetch order wrong");
  chk_load_time: assert property (flash_rd && flash_addr == 24'h002BFE |->
    (!load_done) [*3] ##1 load_done) else $error("load_done timing");
  chk_tbl_accept: assert property (tbl_rd && tbl_addr >= 24'h800000 |=> tbl_valid)
    else $error("read not answered");
  chk_tbl_refuse: assert property (!(tbl_rd && tbl_addr >= 24'h800000) |=>
    !tbl_valid && $stable(tbl_data)) else $error("refused read answered");
  chk_seg_ones: assert property (tbl_valid && $past(tbl_addr) == 24'hF80004 |->
    tbl_data[7:2] == 6'h3F) else $error("unimplemented bits not 1");
  chk_pol_ones: assert property (tbl_valid && $past(tbl_addr) == 24'hF8000C |->
    tbl_data[6:5] == 2'h3) else $error("polarity bits not 1");
  chk_prot_match: assert property (tbl_valid && $past(tbl_addr) == 24'hF80004 &&
    $past(load_done, 2) |-> code_protect != tbl_data[1] && write_protect != tbl_data[0])
    else $error("protect outputs disagree");
  cover property ($rose(load_done));
  cover property (tbl_valid && $past(tbl_addr) == 24'hF8000E);
  cover property (load_done && code_protect);
endmodule // csl_loader_monitor
bind csl_loader csl_loader_monitor i_csl_loader_monitor (.clk, .rst, .flash_addr, .flash_rd,
  .tbl_addr, .tbl_rd, .tbl_data, .tbl_valid, .load_done, .dep_rst, .code_protect, .write_protect);

// *** bench/tb_top.sv ***
// self-checking bench for the config shadow loader
`timescale 1ns/1ps
module tb_top;
  import csl_pkg::*;
  logic clk, rst, flash_rd, tbl_rd, tbl_valid, load_done, dep_rst;
  logic code_protect, write_protect, osc_pin_clkout;
  csl_addr_t flash_addr, tbl_addr;
  csl_word_t flash_data, w_one, w_two;
  csl_byte_t tbl_data, last;
  int n_fail, check_count;
  csl_loader i_csl_loader (.clk, .rst, .flash_addr, .flash_rd, .flash_data, .tbl_rd,
    .tbl_addr, .tbl_data, .tbl_valid, .load_done, .dep_rst, .code_protect,
    .write_protect, .osc_pin_clkout);
  csl_flash_model i_csl_flash_model (.clk, .flash_addr, .flash_rd, .w_one, .w_two,
    .flash_data);
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task ck(input string n, input logic [23:0] e, input logic [23:0] s);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // expected shadow byte; upper word byte never used
  function automatic csl_byte_t ex(input csl_addr_t a, input csl_word_t w1, input csl_word_t w2);
    case (a)
      24'hF80004: ex = {6'h3F, w1[13:12]};
      24'hF80006: ex = {w2[15:14], 1'h1, w2[12:8]};
      24'hF80008: ex = {w2[7:6], w2[4], 2'h3, w2[5], w2[1:0]};
      24'hF8000A: ex = w1[7:0];
      24'hF8000C: ex = {w2[13], 2'h3, w2[2], 4'hF};
      24'hF8000E: ex = {w1[11], 1'h1, w1[15:14], 2'h3, w1[9:8]};
      default: ex = 8'hFF;
    endcase
  endfunction
  task boot(input csl_word_t a, input csl_word_t b);
    @(posedge clk);
    w_one <= a;
    w_two <= b;
    rst <= 1;
    repeat (10) @(posedge clk);
    ck("dep_rst", 1, dep_rst);
    rst <= 0;
    for (int i = 0; i < 20 && load_done !== 1; i++) @(posedge clk);
    ck("load_done", 1, load_done);
    if (load_done !== 1)
      print_verdict;
    repeat (2) @(posedge clk);
    ck("dep_rst", 0, dep_rst);
  endtask
  task rd(input csl_addr_t a, input logic v);
    @(posedge clk);
    tbl_rd <= 1;
    tbl_addr <= a;
    @(posedge clk);
    tbl_rd <= 0;
    #1;
    ck("tbl_valid", v, tbl_valid);
  endtask
  task s_load(input csl_word_t a, input csl_word_t b);
    csl_addr_t x;
    boot(a, b);
    for (x = 24'hF80000; x <= 24'hF80010; x += 24'h2)
    begin
      rd(x, 1'h1);
      ck("tbl_data", ex(x, a, b), tbl_data);
    end
    ck("code_protect", !a[13], code_protect);
    ck("write_protect", !a[12], write_protect);
    ck("osc_pin_clkout", b[5], osc_pin_clkout);
  endtask
  // user-space address must be refused
  task s_refuse;
    last = tbl_data;
    rd(24'h002BFC, 1'h0);
    ck("tbl_data", last, tbl_data);
  endtask
  initial
  begin
    rst = 1;
    tbl_rd = 0;
    tbl_addr = 0;
    w_one = 0;
    w_two = 0;
    n_fail = 0;
    check_count = 0;
    // words keep ones on top and reserved bits as required
    s_load(24'hFF2A5C, 24'hFF9D36);
    s_refuse;
    s_load(24'hFF1B81, 24'hFF62C9);
    // same low halves with a cleared top byte must give the same shadows
    s_load(24'h002A5C, 24'h009D36);
    s_load(24'h000000, 24'h000000);
    print_verdict;
  end
endmodule // tb_top

// *** design/csl_flash_port.sv ***
// registered read port toward program flash with fixed latency
`timescale 1ns/1ps
`include "csl_regs.svh"
module csl_flash_port
  import csl_pkg::*;
#(
  parameter int LATENCY = `CSL_FLASH_LATENCY
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire csl_word_t flash_data,
  output logic valid,
  output csl_word_t data_q
);
  logic [LATENCY-1:0] pipe_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pipe_q <= '0;
    else
      pipe_q <= {pipe_q[LATENCY-2:0], req};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      data_q <= `CSL_ERASED_WORD;
    else if (pipe_q[LATENCY-2])
      data_q <= flash_data;
  end

  assign valid = pipe_q[LATENCY-1];
endmodule // csl_flash_port

// *** design/csl_loader.sv ***
// configuration shadow loader: copies packed flash words into shadow bytes on reset
// Operation
// - programmed bit reads 0, unprogrammed 1
// - shadows read-only, mapped from 0xF80000
// - config space reached only by table reads
// - unpack two top flash words during reset
// - reload on every reset type
// - upper word byte never reaches any shadow
// - erased words enable code protection
// - unimplemented bits read as 1
// - polarity bits always read 1 here
// - osc pin bit factory programmed 0
// - osc pin 0 gives gpio, 1 clock out
`timescale 1ns/1ps
`include "csl_regs.svh"
module csl_loader
  import csl_pkg::*;
#(
  parameter int FLASH_LATENCY = `CSL_FLASH_LATENCY
)
(
  input wire logic clk,
  input wire logic rst,
  output csl_pkg::csl_addr_t flash_addr,
  output logic flash_rd,
  input wire csl_pkg::csl_word_t flash_data,
  input wire logic tbl_rd,
  input wire csl_pkg::csl_addr_t tbl_addr,
  output csl_pkg::csl_byte_t tbl_data,
  output logic tbl_valid,
  output logic load_done,
  output logic dep_rst,
  output logic code_protect,
  output logic write_protect,
  output logic osc_pin_clkout
);
  import csl_pkg::*;

  csl_state_t state_q;
  csl_state_t state_d;
  csl_word_t word_two_q;
  csl_word_t word_one_q;
  csl_byte_t segment_protection_shadow;
  csl_byte_t oscillator_select_shadow;
  csl_byte_t oscillator_config_shadow;
  csl_byte_t watchdog_config_shadow;
  csl_byte_t poweron_pin_config_shadow;
  csl_byte_t debug_channel_shadow;
  logic rd_valid;
  csl_word_t rd_word;
  logic cfg_space;
  logic [15:0] w2;
  logic [15:0] w1;
  csl_addr_t flash_addr_q;
  logic load_done_q;
  logic dep_rst_q;

  csl_flash_port #(
    .LATENCY(FLASH_LATENCY)
  ) u_port (
    .clk(clk),
    .rst(rst),
    .req(flash_rd),
    .flash_data(flash_data),
    .valid(rd_valid),
    .data_q(rd_word)
  );

  // load sequence restarts from idle on any reset source
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      CSL_IDLE: state_d = CSL_REQ_TWO;
      CSL_REQ_TWO: state_d = CSL_WAIT_TWO;
      CSL_WAIT_TWO: if (rd_valid) state_d = CSL_REQ_ONE;
      CSL_REQ_ONE: state_d = CSL_WAIT_ONE;
      CSL_WAIT_ONE: if (rd_valid) state_d = CSL_DONE;
      CSL_DONE: state_d = CSL_DONE;
      default: state_d = CSL_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_q <= CSL_IDLE;
    else
      state_q <= state_d;
  end

  assign flash_rd = (state_q == CSL_REQ_TWO) || (state_q == CSL_REQ_ONE);

  // address from a flop, decoded one cycle ahead so it lines up with the request
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flash_addr_q <= `CSL_WORD_TWO_ADDR;
    else if (state_d == CSL_REQ_ONE)
      flash_addr_q <= `CSL_WORD_ONE_ADDR;
    else
      flash_addr_q <= `CSL_WORD_TWO_ADDR;
  end

  assign flash_addr = flash_addr_q;

  // words start erased so a half-finished load leaves protection on
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      word_two_q <= `CSL_ERASED_WORD;
    else if (state_q == CSL_WAIT_TWO && rd_valid)
      word_two_q <= rd_word;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      word_one_q <= `CSL_ERASED_WORD;
    else if (state_q == CSL_WAIT_ONE && rd_valid)
      word_one_q <= rd_word;
  end

  // upper byte dropped here, never unpacked
  assign w2 = word_two_q[`CSL_WORD_LOW_MSB:0];
  assign w1 = word_one_q[`CSL_WORD_LOW_MSB:0];

  // bits copied raw: 0 means programmed, 1 unprogrammed
  // all-ones default covers every unimplemented position
  always_comb
  begin
    segment_protection_shadow = `CSL_UNPROG_BYTE;
    segment_protection_shadow[`CSL_SEG_CODE_PROT_BIT] = w1[`CSL_W1_CODE_PROT];
    segment_protection_shadow[`CSL_SEG_WRITE_PROT_BIT] = w1[`CSL_W1_WRITE_PROT];
  end

  always_comb
  begin
    oscillator_select_shadow = `CSL_UNPROG_BYTE;
    oscillator_select_shadow[`CSL_SEL_TWO_SPEED] = w2[`CSL_W2_TWO_SPEED];
    oscillator_select_shadow[`CSL_SEL_PWM_LOCK] = w2[`CSL_W2_PWM_LOCK];
    oscillator_select_shadow[`CSL_SEL_WDT_WIN] = w2[`CSL_W2_WDT_WIN];
    oscillator_select_shadow[`CSL_SEL_OSC_SRC] = w2[`CSL_W2_OSC_SRC];
  end

  always_comb
  begin
    oscillator_config_shadow = `CSL_UNPROG_BYTE;
    oscillator_config_shadow[`CSL_CFG_CLK_SW] = w2[`CSL_W2_CLK_SW];
    oscillator_config_shadow[`CSL_CFG_PIN_ONCE] = w2[`CSL_W2_PIN_ONCE];
    oscillator_config_shadow[`CSL_OSC_PIN_BIT] = w2[`CSL_W2_OSC_PIN];
    oscillator_config_shadow[`CSL_CFG_PRI_OSC] = w2[`CSL_W2_PRI_OSC];
  end

  always_comb
  begin
    watchdog_config_shadow = w1[`CSL_W1_WDT];
  end

  // polarity positions forced high on this variant, whatever flash holds
  always_comb
  begin
    poweron_pin_config_shadow = `CSL_UNPROG_BYTE;
    poweron_pin_config_shadow[`CSL_POR_PWM_PIN] = w2[`CSL_W2_PWM_PIN];
    poweron_pin_config_shadow[`CSL_POR_HI_POL_BIT] = `CSL_FORCED_ONE;
    poweron_pin_config_shadow[`CSL_POR_LO_POL_BIT] = `CSL_FORCED_ONE;
    poweron_pin_config_shadow[`CSL_POR_ALT_I2C] = w2[`CSL_W2_ALT_I2C];
  end

  // reserved bits pass through as programmed, not corrected here
  always_comb
  begin
    debug_channel_shadow = `CSL_UNPROG_BYTE;
    debug_channel_shadow[`CSL_DBG_TOOL_RSV] = w1[`CSL_W1_TOOL_RSV];
    debug_channel_shadow[`CSL_DBG_RSV_HI] = w1[`CSL_W1_RSV_HI];
    debug_channel_shadow[`CSL_DBG_RSV_LO] = w1[`CSL_W1_RSV_LO];
    debug_channel_shadow[`CSL_DBG_CH] = w1[`CSL_W1_DBG_CH];
  end

  csl_table_read u_tbl (
    .clk(clk),
    .rst(rst),
    .rd_en(tbl_rd && cfg_space),
    .rd_addr(tbl_addr),
    .seg_prot(segment_protection_shadow),
    .osc_sel(oscillator_select_shadow),
    .osc_cfg(oscillator_config_shadow),
    .wdt_cfg(watchdog_config_shadow),
    .por_pin(poweron_pin_config_shadow),
    .debug_ch(debug_channel_shadow),
    .rd_data_q(tbl_data),
    .rd_valid_q(tbl_valid)
  );

  // no write path exists into the shadows
  assign cfg_space = (tbl_addr >= `CSL_CFG_SPACE_BASE);

  // registered so the dependents' reset cannot glitch on a state decode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      load_done_q <= 1'h0;
      dep_rst_q <= 1'h1;
    end
    else
    begin
      load_done_q <= (state_d == CSL_DONE);
      dep_rst_q <= (state_d != CSL_DONE);
    end
  end

  assign load_done = load_done_q;
  assign dep_rst = dep_rst_q;

  // status outputs registered, safe values until loaded
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      code_protect <= 1'h1;
      write_protect <= 1'h1;
      osc_pin_clkout <= 1'h0;
    end
    else
    begin
      code_protect <= !segment_protection_shadow[`CSL_SEG_CODE_PROT_BIT];
      write_protect <= !segment_protection_shadow[`CSL_SEG_WRITE_PROT_BIT];
      osc_pin_clkout <= oscillator_config_shadow[`CSL_OSC_PIN_BIT];
    end
  end
endmodule // csl_loader

// *** design/csl_pkg.sv ***
// types shared by the configuration shadow loader
package csl_pkg;
  typedef enum logic [2:0] {
    CSL_IDLE = 3'b000,
    CSL_REQ_TWO = 3'b001,
    CSL_WAIT_TWO = 3'b010,
    CSL_REQ_ONE = 3'b011,
    CSL_WAIT_ONE = 3'b100,
    CSL_DONE = 3'b101
  } csl_state_t;
  typedef logic [23:0] csl_addr_t;
  typedef logic [23:0] csl_word_t;
  typedef logic [7:0] csl_byte_t;
endpackage

// *** design/csl_regs.svh ***
// register addresses, field positions and load timing constants for the config loader
`ifndef CSL_REGS_SVH
`define CSL_REGS_SVH
`define CSL_WORD_TWO_ADDR 24'h002BFC
`define CSL_WORD_ONE_ADDR 24'h002BFE
`define CSL_CFG_SPACE_BASE 24'h800000
`define CSL_SHADOW_BASE 24'hF80000
`define CSL_SEG_PROT_ADDR 24'hF80004
`define CSL_OSC_SEL_ADDR 24'hF80006
`define CSL_OSC_CFG_ADDR 24'hF80008
`define CSL_WDT_CFG_ADDR 24'hF8000A
`define CSL_POR_PIN_ADDR 24'hF8000C
`define CSL_DEBUG_ADDR 24'hF8000E
`define CSL_UNPROG_BYTE 8'hFF
`define CSL_ERASED_WORD 24'h000000
`define CSL_WORD_LOW_MSB 15
`define CSL_OSC_PIN_BIT 2
`define CSL_SEG_CODE_PROT_BIT 1
`define CSL_SEG_WRITE_PROT_BIT 0
`define CSL_POR_HI_POL_BIT 6
`define CSL_POR_LO_POL_BIT 5
`define CSL_FORCED_ONE 1'h1
`define CSL_FLASH_LATENCY 2
// packed word field positions, low half only
`define CSL_W1_RSV_HI 15
`define CSL_W1_RSV_LO 14
`define CSL_W1_CODE_PROT 13
`define CSL_W1_WRITE_PROT 12
`define CSL_W1_TOOL_RSV 11
`define CSL_W1_DBG_CH 9:8
`define CSL_W1_WDT 7:0
`define CSL_W2_TWO_SPEED 15
`define CSL_W2_PWM_LOCK 14
`define CSL_W2_PWM_PIN 13
`define CSL_W2_WDT_WIN 12:11
`define CSL_W2_OSC_SRC 10:8
`define CSL_W2_CLK_SW 7:6
`define CSL_W2_OSC_PIN 5
`define CSL_W2_PIN_ONCE 4
`define CSL_W2_ALT_I2C 2
`define CSL_W2_PRI_OSC 1:0
// shadow byte field positions
`define CSL_SEL_TWO_SPEED 7
`define CSL_SEL_PWM_LOCK 6
`define CSL_SEL_WDT_WIN 4:3
`define CSL_SEL_OSC_SRC 2:0
`define CSL_CFG_CLK_SW 7:6
`define CSL_CFG_PIN_ONCE 5
`define CSL_CFG_PRI_OSC 1:0
`define CSL_POR_PWM_PIN 7
`define CSL_POR_ALT_I2C 4
`define CSL_DBG_TOOL_RSV 7
`define CSL_DBG_RSV_HI 5
`define CSL_DBG_RSV_LO 4
`define CSL_DBG_CH 1:0
`endif

// *** design/csl_table_read.sv ***
// table-read decoder for the read-only shadow bytes
`timescale 1ns/1ps
`include "csl_regs.svh"
module csl_table_read
  import csl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rd_en,
  input wire csl_addr_t rd_addr,
  input wire csl_byte_t seg_prot,
  input wire csl_byte_t osc_sel,
  input wire csl_byte_t osc_cfg,
  input wire csl_byte_t wdt_cfg,
  input wire csl_byte_t por_pin,
  input wire csl_byte_t debug_ch,
  output csl_byte_t rd_data_q,
  output logic rd_valid_q
);
  csl_byte_t rd_data_d;

  always_comb
  begin
    case (rd_addr)
      `CSL_SEG_PROT_ADDR: rd_data_d = seg_prot;
      `CSL_OSC_SEL_ADDR: rd_data_d = osc_sel;
      `CSL_OSC_CFG_ADDR: rd_data_d = osc_cfg;
      `CSL_WDT_CFG_ADDR: rd_data_d = wdt_cfg;
      `CSL_POR_PIN_ADDR: rd_data_d = por_pin;
      `CSL_DEBUG_ADDR: rd_data_d = debug_ch;
      // unmapped config space reads as unprogrammed
      default: rd_data_d = `CSL_UNPROG_BYTE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data_q <= `CSL_UNPROG_BYTE;
      rd_valid_q <= 1'h0;
    end
    else
    begin
      rd_valid_q <= rd_en;
      if (rd_en)
        rd_data_q <= rd_data_d;
    end
  end
endmodule // csl_table_read
